// >>> rtl/wccop_defines.vh
// constants for the watchdog-clear and complement instruction block
`ifndef WCCOP_DEFINES_VH
`define WCCOP_DEFINES_VH

// instruction encodings
`define WCCOP_OP_WDT_CLEAR 16'h0004
`define WCCOP_OP_COMPL_HI 6'h07
`define WCCOP_OP_ZERO_HI 7'h35

// instruction word fields
`define WCCOP_DEST_BIT 9
`define WCCOP_ACCESS_BIT 8
`define WCCOP_FILE_MSB 7

// addressing
`define WCCOP_INDEXED_LIMIT 8'h5F
`define WCCOP_ACCESS_SPLIT 8'h60
`define WCCOP_ACCESS_HIGH_BASE 12'hF00

// quarter-cycle phases of one instruction cycle
`define WCCOP_PH_DECODE 2'h0
`define WCCOP_PH_READ 2'h1
`define WCCOP_PH_PROCESS 2'h2
`define WCCOP_PH_WRITE 2'h3

// reset values
`define WCCOP_RST_FLAG_LOW 1'b1
`define WCCOP_RST_WORK 8'h00
`define WCCOP_RST_BANK 4'h0

`endif

// >>> rtl/wccop_dmem.v
// small data memory with synchronous write and registered read data
`timescale 1ns/10ps
`default_nettype none

module wccop_dmem #(
    parameter AW = 12,
    parameter DW = 8
) (
    input wire mclk,
    input wire rd_en,
    input wire [AW-1:0] rd_addr,
    output reg [DW-1:0] rd_data,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [DW-1:0] wr_data
);

    // storage array, contents undefined until written
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // read first in the array, read data comes out of a register
    always @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule // wccop_dmem

`default_nettype wire

// >>> rtl/wccop_core.v
// core slice executing watchdog clear, complement and zero-register
`timescale 1ns/10ps
`default_nettype none
`include "wccop_defines.vh"

module wccop_core #(
    parameter AW = 12,
    parameter DW = 8,
    parameter BW = 4
) (
    input wire mclk,
    input wire reset,
    input wire instr_valid,
    input wire [15:0] instr_word,
    input wire ext_set_enable,
    input wire [AW-1:0] index_base,
    input wire bank_load,
    input wire [BW-1:0] bank_load_data,
    input wire timeout_event,
    input wire sleep_event,
    input wire preload_en,
    input wire [AW-1:0] preload_addr,
    input wire [DW-1:0] preload_data,
    output reg instr_taken_reg,
    output reg [1:0] phase_reg,
    output reg watchdog_counter_clear_reg,
    output reg timeout_flag_low_reg,
    output reg sleep_flag_low_reg,
    output reg neg_flag_reg,
    output reg zero_flag_reg,
    output reg [DW-1:0] working_register_reg,
    output reg [BW-1:0] bank_choice_register_reg,
    output reg mem_write_reg,
    output reg [AW-1:0] mem_write_addr_reg,
    output reg [DW-1:0] mem_write_data_reg
);

    // decoded instruction held for the whole instruction cycle
    reg [15:0] ir_reg;
    reg ir_valid_reg;
    reg [DW-1:0] result_reg;
    reg [AW-1:0] addr_reg;

    // operand from the data memory, valid in the process phase
    wire [DW-1:0] rd_data;

    // decode helpers
    wire is_wdt_clear;
    wire is_compl;
    wire is_zero;
    wire [AW-1:0] eff_addr;
    reg core_wr;
    reg [AW-1:0] core_wr_addr;
    reg [DW-1:0] core_wr_data;

    // effective data address from file field, access bit and modes
    function [AW-1:0] wccop_addr;
        input [7:0] file_addr;
        input access_bit;
        input ext_on;
        input [BW-1:0] bank;
        input [AW-1:0] base;
        begin
            if (access_bit) begin
                // banked: bank choice register supplies the upper bits
                wccop_addr = {bank, file_addr};
            end else if (ext_on && (file_addr <= `WCCOP_INDEXED_LIMIT)) begin
                // indexed literal offset relative to the index base
                wccop_addr = base + {{(AW-8){1'b0}}, file_addr};
            end else if (file_addr < `WCCOP_ACCESS_SPLIT) begin
                // lower access bank half sits at the bottom of memory
                wccop_addr = {{(AW-8){1'b0}}, file_addr};
            end else begin
                // upper access bank half maps onto the special registers
                wccop_addr = `WCCOP_ACCESS_HIGH_BASE | {{(AW-8){1'b0}}, file_addr};
            end
        end
    endfunction

    assign is_wdt_clear = ir_valid_reg && (ir_reg == `WCCOP_OP_WDT_CLEAR);
    assign is_compl = ir_valid_reg && (ir_reg[15:10] == `WCCOP_OP_COMPL_HI);
    assign is_zero = ir_valid_reg && (ir_reg[15:9] == `WCCOP_OP_ZERO_HI);
    assign eff_addr = wccop_addr(ir_reg[`WCCOP_FILE_MSB:0], ir_reg[`WCCOP_ACCESS_BIT],
                                 ext_set_enable, bank_choice_register_reg, index_base);

    // memory write port: the core's own write phase wins over preloading
    always @* begin
        core_wr = 1'b0;
        core_wr_addr = preload_addr;
        core_wr_data = preload_data;
        if ((phase_reg == `WCCOP_PH_WRITE) && is_compl && ir_reg[`WCCOP_DEST_BIT]) begin
            core_wr = 1'b1;
            core_wr_addr = addr_reg;
            core_wr_data = result_reg;
        end else if ((phase_reg == `WCCOP_PH_WRITE) && is_zero) begin
            core_wr = 1'b1;
            core_wr_addr = addr_reg;
            core_wr_data = {DW{1'b0}};
        end else if (preload_en) begin
            core_wr = 1'b1;
        end
    end

    // data memory, read issued in the read phase
    wccop_dmem #(
        .AW(AW),
        .DW(DW)
    ) u_dmem (
        .mclk(mclk),
        .rd_en(phase_reg == `WCCOP_PH_READ),
        .rd_addr(eff_addr),
        .rd_data(rd_data),
        .wr_en(core_wr),
        .wr_addr(core_wr_addr),
        .wr_data(core_wr_data)
    );

    // quarter-cycle sequencer and instruction latch
    always @(posedge mclk) begin
        if (reset) begin
            phase_reg <= `WCCOP_PH_DECODE;
            ir_reg <= 16'h0000;
            ir_valid_reg <= 1'b0;
            instr_taken_reg <= 1'b0;
            addr_reg <= {AW{1'b0}};
        end else begin
            // phases advance every clock, four clocks per instruction
            phase_reg <= phase_reg + 2'h1;
            instr_taken_reg <= 1'b0;
            if (phase_reg == `WCCOP_PH_DECODE) begin
                // one word per instruction, sampled only in decode
                ir_reg <= instr_word;
                ir_valid_reg <= instr_valid;
                instr_taken_reg <= instr_valid;
            end
            if (phase_reg == `WCCOP_PH_READ) begin
                // freeze the target so a bank change mid-cycle is harmless
                addr_reg <= eff_addr;
            end
        end
    end

    // process phase: form the result from the operand
    always @(posedge mclk) begin
        if (reset) begin
            result_reg <= {DW{1'b0}};
        end else if (phase_reg == `WCCOP_PH_PROCESS) begin
            if (is_compl) begin
                result_reg <= ~rd_data;
            end else begin
                result_reg <= {DW{1'b0}};
            end
        end
    end

    // status flags, working register and bank choice
    always @(posedge mclk) begin
        if (reset) begin
            timeout_flag_low_reg <= `WCCOP_RST_FLAG_LOW;
            sleep_flag_low_reg <= `WCCOP_RST_FLAG_LOW;
            neg_flag_reg <= 1'b0;
            zero_flag_reg <= 1'b0;
            working_register_reg <= `WCCOP_RST_WORK;
            bank_choice_register_reg <= `WCCOP_RST_BANK;
            watchdog_counter_clear_reg <= 1'b0;
        end else begin
            watchdog_counter_clear_reg <= 1'b0;
            if (bank_load) begin
                bank_choice_register_reg <= bank_load_data;
            end
            // watchdog clear acts in the process phase: clear pulse and the two low flags only
            if ((phase_reg == `WCCOP_PH_PROCESS) && is_wdt_clear) begin
                watchdog_counter_clear_reg <= 1'b1;
                timeout_flag_low_reg <= 1'b1;
                sleep_flag_low_reg <= 1'b1;
            end
            // hardware events come last so a same-cycle event is never lost
            if (timeout_event) begin
                timeout_flag_low_reg <= 1'b0;
            end
            if (sleep_event) begin
                sleep_flag_low_reg <= 1'b0;
            end
            if ((phase_reg == `WCCOP_PH_WRITE) && is_compl) begin
                // only negative and zero follow the complement result
                neg_flag_reg <= result_reg[DW-1];
                zero_flag_reg <= (result_reg == {DW{1'b0}});
                if (!ir_reg[`WCCOP_DEST_BIT]) begin
                    working_register_reg <= result_reg;
                end
            end
            if ((phase_reg == `WCCOP_PH_WRITE) && is_zero) begin
                zero_flag_reg <= 1'b1;
            end
        end
    end

    // mirror of every memory write, visible one clock later
    always @(posedge mclk) begin
        if (reset) begin
            mem_write_reg <= 1'b0;
            mem_write_addr_reg <= {AW{1'b0}};
            mem_write_data_reg <= {DW{1'b0}};
        end else begin
            mem_write_reg <= core_wr;
            if (core_wr) begin
                mem_write_addr_reg <= core_wr_addr;
                mem_write_data_reg <= core_wr_data;
            end
        end
    end

endmodule // wccop_core

`default_nettype wire

// >>> verification/wccop_properties.sv
// assertion checker for the watchdog-clear and complement core
`timescale 1ns/10ps
`default_nettype none
module wccop_properties (
    input wire logic mclk,
    input wire logic reset,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic timeout_event,
    input wire logic instr_taken_reg,
    input wire logic [1:0] phase_reg,
    input wire logic watchdog_counter_clear_reg,
    input wire logic timeout_flag_low_reg,
    input wire logic sleep_flag_low_reg,
    input wire logic neg_flag_reg,
    input wire logic zero_flag_reg,
    input wire logic [7:0] working_register_reg,
    input wire logic mem_write_reg,
    input wire logic [7:0] mem_write_data_reg
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // each take sequence matches one cycle after the decode edge
    sequence wd_take; instr_taken_reg && $past(instr_word) == 16'h0004; endsequence
    sequence cm_take; instr_taken_reg && $past(instr_word[15:9]) == 7'h0E; endsequence
    sequence zr_take; instr_taken_reg && $past(instr_word[15:9]) == 7'h35; endsequence
    chk_wd_pulse: assert property (wd_take |-> ##2 watchdog_counter_clear_reg)
        else $error("watchdog clear pulse missing");
    chk_wd_cause: assert property (watchdog_counter_clear_reg |->
        $past(instr_taken_reg, 2) && $past(instr_word, 3) == 16'h0004)
        else $error("watchdog clear pulse without its opcode");
    chk_wd_single: assert property (watchdog_counter_clear_reg |=> !watchdog_counter_clear_reg)
        else $error("watchdog clear pulse too long");
    chk_wd_flags: assert property (wd_take ##1 !timeout_event |=> timeout_flag_low_reg
        && sleep_flag_low_reg)
        else $error("low flags not set by watchdog clear");
    chk_event_wins: assert property (timeout_event |=> !timeout_flag_low_reg)
        else $error("timeout event did not clear flag");
    chk_take_rule: assert property (instr_taken_reg == ($past(instr_valid)
        && $past(phase_reg) == 2'h0 && !$past(reset)))
        else $error("instruction taken outside decode phase");
    chk_phase_step: assert property (1'b1 |=> phase_reg == $past(phase_reg) + 2'h1)
        else $error("phase did not advance");
    chk_compl_nz: assert property (cm_take |-> ##3 (neg_flag_reg == working_register_reg[7]
        && zero_flag_reg == (working_register_reg == 8'h00)))
        else $error("complement flags disagree with result");
    chk_zero_write: assert property (zr_take |-> ##3 zero_flag_reg ##[0:1]
        (mem_write_reg && mem_write_data_reg == 8'h00))
        else $error("zero register write missing");
endmodule // wccop_properties
bind wccop_core wccop_properties u_props (.mclk, .reset, .instr_valid, .instr_word,
    .timeout_event, .instr_taken_reg, .phase_reg, .watchdog_counter_clear_reg,
    .timeout_flag_low_reg, .sleep_flag_low_reg, .neg_flag_reg, .zero_flag_reg,
    .working_register_reg, .mem_write_reg, .mem_write_data_reg);
`default_nettype wire

// >>> verification/test_wccop_core.sv
// self-checking bench for the watchdog-clear and complement core
`timescale 1ns/10ps
`default_nettype none
module test_wccop_core;
    logic mclk = 1'b0, reset = 1'b1, instr_valid = 1'b0, ext_set_enable = 1'b0;
    logic bank_load = 1'b0, timeout_event = 1'b0, sleep_event = 1'b0, preload_en = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic [11:0] index_base = 12'h100, preload_addr = 12'h000, mem_write_addr_reg, cap_addr;
    logic [3:0] bank_load_data = 4'h3, bank_choice_register_reg;
    logic [7:0] preload_data = 8'h00, working_register_reg, mem_write_data_reg, cap_data, e;
    logic [1:0] phase_reg, nz;
    logic instr_taken_reg, watchdog_counter_clear_reg, timeout_flag_low_reg, wd_seen;
    logic sleep_flag_low_reg, neg_flag_reg, zero_flag_reg, mem_write_reg;
    int errors = 0, samples_checked = 0;
    // row: word, effective address, preloaded data, extended set
    typedef struct {logic [15:0] w; logic [11:0] a; logic [7:0] d; logic x;} wccop_row_t;
    wccop_row_t rows [6] = '{'{16'h1C20, 12'h020, 8'h13, 1'b0},
        '{16'h1F45, 12'h345, 8'hFF, 1'b0}, '{16'h1E80, 12'hF80, 8'h0F, 1'b0},
        '{16'h1C5F, 12'h15F, 8'h80, 1'b1}, '{16'h1E60, 12'hF60, 8'h55, 1'b1},
        '{16'h1E00, 12'h100, 8'h00, 1'b1}};

    wccop_core DUT (.*);

    always #50 mclk = ~mclk;

    // remember the last memory write and any watchdog clear pulse
    always @(posedge mclk) begin
        if (mem_write_reg === 1'b1) begin
            cap_addr <= mem_write_addr_reg;
            cap_data <= mem_write_data_reg;
        end
        if (watchdog_counter_clear_reg === 1'b1) wd_seen <= 1'b1;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // present a word so that the next phase-0 edge takes it, then let it finish
    task automatic run(input logic [15:0] w);
        @(posedge mclk);
        while (phase_reg !== 2'h3) @(posedge mclk);
        instr_valid <= 1'b1;
        instr_word <= w;
        @(posedge mclk);
        instr_valid <= 1'b0;
        repeat (5) @(posedge mclk);
        #1;
    endtask

    // preload only between instructions, a core write would drop it
    task automatic put(input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        preload_en <= 1'b1;
        preload_addr <= a;
        preload_data <= d;
        @(posedge mclk);
        preload_en <= 1'b0;
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // hang guard, far beyond the roughly 120 cycles the tests need
    initial begin
        #100000;
        errors++;
        report_and_stop;
    end

    initial begin
        repeat (12) @(posedge mclk);
        #1 check({4'h0, timeout_flag_low_reg, sleep_flag_low_reg, neg_flag_reg, zero_flag_reg,
            working_register_reg}, 16'h0C00);
        reset <= 1'b0;
        @(posedge mclk);
        bank_load <= 1'b1;
        @(posedge mclk);
        bank_load <= 1'b0;
        #1 check({12'h0, bank_choice_register_reg}, 16'h0003);
        foreach (rows[i]) begin
            ext_set_enable <= rows[i].x;
            put(rows[i].a, rows[i].d);
            run(rows[i].w);
            e = ~rows[i].d;
            if (rows[i].w[9]) begin
                check({4'h0, cap_addr}, {4'h0, rows[i].a});
                check({8'h00, cap_data}, {8'h00, e});
            end else begin
                check({8'h00, working_register_reg}, {8'h00, e});
            end
            check({14'h0, neg_flag_reg, zero_flag_reg}, {14'h0, e[7], e == 8'h00});
        end
        // drop both low flags by events, then the watchdog clear must raise them
        @(posedge mclk);
        timeout_event <= 1'b1;
        sleep_event <= 1'b1;
        @(posedge mclk);
        timeout_event <= 1'b0;
        sleep_event <= 1'b0;
        #1 check({14'h0, timeout_flag_low_reg, sleep_flag_low_reg}, 16'h0000);
        nz = {neg_flag_reg, zero_flag_reg};
        wd_seen = 1'b0;
        run(16'h0004);
        check({15'h0, wd_seen}, 16'h0001);
        check({14'h0, timeout_flag_low_reg, sleep_flag_low_reg}, 16'h0003);
        check({14'h0, neg_flag_reg, zero_flag_reg}, {14'h0, nz});
        // unrelated opcode must not clear the watchdog
        wd_seen = 1'b0;
        run(16'h0014);
        check({15'h0, wd_seen}, 16'h0000);
        put(12'h345, 8'h5A);
        run(16'h6B45);
        check({4'h0, cap_addr}, 16'h0345);
        check({7'h0, zero_flag_reg, cap_data}, 16'h0100);
        report_and_stop;
    end
endmodule // test_wccop_core
`default_nettype wire
